// ### irq_wake_pkg.sv
// irq_wake_pkg: constants for the interrupt and wake control block
// assumes an apb slave with 32-bit data, one word per register
package irq_wake_pkg;

    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [11:0] SYS_OPT_ADDR    = 12'h011;
    localparam logic [11:0] SYS_OPT_OFF     = 12'h044;
    localparam logic [11:0] CORE_TMR_OFF    = 12'h080;
    localparam logic [11:0] TMR_IRQ_OFF     = 12'h084;
    localparam logic [11:0] KEYPAD_OFF      = 12'h088;
    localparam logic [11:0] CPU_CTRL_OFF    = 12'h08C;
    localparam logic [11:0] CPU_STAT_OFF    = 12'h090;

    // ------------------------------------------------------------
    // system option fields and reset
    // ------------------------------------------------------------
    localparam int          UV_FLAG_BIT     = 7;
    localparam int          UV_EN_BIT       = 6;
    localparam int          UV_PWR_BIT      = 5;
    localparam int          CLK_SEL_BIT     = 4;
    localparam int          PIN_SENSE_BIT   = 3;
    localparam logic [7:0]  SYS_OPT_RST     = 8'h00;

    // core timer control fields
    localparam int          TICK_FLAG_BIT   = 7;
    localparam int          WRAP_FLAG_BIT   = 6;
    localparam int          TICK_EN_BIT     = 5;
    localparam int          WRAP_EN_BIT     = 4;
    localparam logic [7:0]  TICK_RATE_RST   = 8'h10;

    // cpu control fields
    localparam int          MASK_BIT        = 0;
    localparam int          STOP_BIT        = 1;
    localparam int          WAIT_BIT        = 2;
    localparam int          DONE_BIT        = 3;
    localparam int          ACK_BIT         = 4;
    localparam int          RSP_BIT         = 5;
    localparam int          PUSH_INT_BIT    = 6;
    localparam int          PUSH_SUB_BIT    = 7;

    // ------------------------------------------------------------
    // vectors and stack
    // ------------------------------------------------------------
    localparam logic [15:0] VEC_RESET       = 16'h3FFE;
    localparam logic [15:0] VEC_EXT         = 16'h3FFA;
    localparam logic [15:0] VEC_CORE        = 16'h3FF8;
    localparam logic [15:0] VEC_TMR         = 16'h3FF6;
    localparam logic [15:0] VEC_UV          = 16'h3FF4;
    localparam logic [15:0] STACK_BASE      = 16'h00C0;
    localparam logic [5:0]  SP_TOP          = 6'h3F;
    localparam logic [5:0]  PUSH_INT_BYTES  = 6'h05;
    localparam logic [5:0]  PUSH_SUB_BYTES  = 6'h02;
    localparam logic [7:0]  CORE_MAX        = 8'hFF;

    typedef enum logic [2:0]
    {
        RUN_S  = 3'b001,
        WAIT_S = 3'b010,
        STOP_S = 3'b100
    } power_state_t;

endpackage

// ### irq_wake_ctrl.sv
// irq_wake_ctrl: maskable interrupt gathering, vectors, wake and stack pointer
// assumes apb master on clk_i, pins from outside, cpu core reports via registers
//
// How it works
// - mask bit set blocks every maskable request; clearing it lets pending ones through
// - pin sense bit selects edge-only or edge-and-level external pin
// - external latch holds one pulse while masked, cleared on acknowledge
// - core timer requests when tick or wrap flag set with its enable; one vector
// - after tick enable set, tick flag sets after programmed rate plus one core counts
// - wrap enable set: wrap flag sets when core counter rolls FF to 00
// - timer requests when any of five flags meets its enable; one vector
// - keypad input lines or together, gated by keypad enable, share external vector
// - undervolt request fetches its own vector pair
// - system option register at 0x11, layout fixed, resets to zero
// - undervolt flag read-only, set by detector when option, power, enable
// - writing enable zero clears undervolt flag; setting enable rearms
// - undervolt enabled: flag set with mask clear raises cpu request
// - undervolt works only with undervolt reset option present
// - reset selects reset vector and sets mask bit
// - stop sleeps until external, undervolt, keypad request or reset
// - wait ends on any request or reset using normal vectors
// - reset or stack reset instruction sets pointer to 00FF
// - stack is 64 bytes at 00C0 wrapping; interrupt five bytes, call two
// - requests wait until instruction done before being taken
// - highest priority pending request is serviced first
//
// Local design decision: the APB slave port.
module irq_wake_ctrl
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_b_i,
    // apb slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // pins and sources
    input  wire logic        irq_pin_b_i,
    input  wire logic [7:0]  keypad_lines_i,
    input  wire logic [7:0]  keypad_is_input_i,
    input  wire logic        undervolt_detect_i,
    input  wire logic        undervolt_reset_opt_i,
    input  wire logic [4:0]  timer_flags_i,
    input  wire logic [4:0]  timer_enables_i,
    input  wire logic        timer_tick_i,
    // cpu side
    output logic             cpu_irq_o,
    output logic      [15:0] vector_addr_o,
    output logic      [15:0] stack_addr_o,
    output logic             osc_run_o,
    output logic             cpu_clk_run_o
);
    import irq_wake_pkg::*;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [2:0] irq_sync_ff, nxt_irq_sync;
    logic [7:0] kp_s1_ff, kp_s2_ff;
    logic [1:0] uv_sync_ff, nxt_uv_sync;
    logic [7:0] nxt_kp_s1, nxt_kp_s2;

    always_comb
    begin
        nxt_irq_sync = {irq_sync_ff[1:0], ~irq_pin_b_i};
        nxt_uv_sync  = {uv_sync_ff[0], undervolt_detect_i};
        nxt_kp_s1    = keypad_lines_i;
        nxt_kp_s2    = kp_s1_ff;
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            irq_sync_ff <= 3'h0;
            uv_sync_ff  <= 2'h0;
            kp_s1_ff    <= 8'h00;
            kp_s2_ff    <= 8'h00;
        end
        else
        begin
            irq_sync_ff <= nxt_irq_sync;
            uv_sync_ff  <= nxt_uv_sync;
            kp_s1_ff    <= nxt_kp_s1;
            kp_s2_ff    <= nxt_kp_s2;
        end
    end

    logic irq_level;
    logic irq_edge;
    logic kp_any;
    assign irq_level = irq_sync_ff[1];
    assign irq_edge  = irq_sync_ff[1] & ~irq_sync_ff[2];
    assign kp_any    = |(kp_s2_ff & keypad_is_input_i);

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    logic [7:0]   sys_opt_ff, nxt_sys_opt;
    logic [7:0]   core_ctl_ff, nxt_core_ctl;
    logic [7:0]   tick_rate_ff, nxt_tick_rate;
    logic [7:0]   core_cnt_ff, nxt_core_cnt;
    logic [7:0]   tick_cnt_ff, nxt_tick_cnt;
    logic         kp_en_ff, nxt_kp_en;
    logic         kp_flag_ff, nxt_kp_flag;
    logic         ext_latch_ff, nxt_ext_latch;
    logic         mask_ff, nxt_mask;
    logic [5:0]   sp_ff, nxt_sp;
    logic [15:0]  vec_ff, nxt_vec;
    power_state_t pwr_ff, nxt_pwr;

    logic wr_en;
    logic rd_en;
    logic [7:0] wb;
    assign wr_en = psel_i & penable_i & pwrite_i;
    assign rd_en = psel_i & penable_i & ~pwrite_i;
    assign wb    = pwdata_i[7:0];

    logic sys_wr, core_wr, kp_wr, cpu_wr;
    assign sys_wr  = wr_en & ((paddr_i == SYS_OPT_ADDR) | (paddr_i == SYS_OPT_OFF));
    assign core_wr = wr_en & (paddr_i == CORE_TMR_OFF);
    assign kp_wr   = wr_en & (paddr_i == KEYPAD_OFF);
    assign cpu_wr  = wr_en & (paddr_i == CPU_CTRL_OFF);

    logic insn_done, ack, rsp, push_int, push_sub;
    assign insn_done = cpu_wr & wb[DONE_BIT];
    assign ack       = cpu_wr & wb[ACK_BIT];
    assign rsp       = cpu_wr & wb[RSP_BIT];
    assign push_int  = cpu_wr & wb[PUSH_INT_BIT];
    assign push_sub  = cpu_wr & wb[PUSH_SUB_BIT];

    // ------------------------------------------------------------
    // request sources
    // ------------------------------------------------------------
    logic ext_req, core_req, tmr_req, uv_req, uv_set;
    logic core_wrap, tick_hit;

    assign core_wrap = timer_tick_i & (core_cnt_ff == CORE_MAX);
    assign tick_hit  = timer_tick_i & core_ctl_ff[TICK_EN_BIT]
                       & (tick_cnt_ff == tick_rate_ff);
    assign uv_set    = uv_sync_ff[1] & undervolt_reset_opt_i
                       & sys_opt_ff[UV_PWR_BIT] & sys_opt_ff[UV_EN_BIT];

    assign ext_req  = ext_latch_ff
                      | (sys_opt_ff[PIN_SENSE_BIT] & irq_level)
                      | (kp_flag_ff & kp_en_ff);
    assign core_req = (core_ctl_ff[TICK_FLAG_BIT] & core_ctl_ff[TICK_EN_BIT])
                      | (core_ctl_ff[WRAP_FLAG_BIT] & core_ctl_ff[WRAP_EN_BIT]);
    assign tmr_req  = |(timer_flags_i & timer_enables_i);
    assign uv_req   = sys_opt_ff[UV_FLAG_BIT] & sys_opt_ff[UV_EN_BIT];

    logic any_req;
    assign any_req = ext_req | core_req | tmr_req | uv_req;

    always_comb
    begin
        nxt_sys_opt   = sys_opt_ff;
        nxt_core_ctl  = core_ctl_ff;
        nxt_tick_rate = tick_rate_ff;
        nxt_core_cnt  = core_cnt_ff;
        nxt_tick_cnt  = tick_cnt_ff;
        nxt_kp_en     = kp_en_ff;
        nxt_kp_flag   = kp_flag_ff;
        nxt_ext_latch = ext_latch_ff;
        nxt_mask      = mask_ff;
        nxt_sp        = sp_ff;
        nxt_vec       = vec_ff;
        nxt_pwr       = pwr_ff;
        // system options; flag is read-only
        if (sys_wr)
        begin
            nxt_sys_opt[6:3] = wb[6:3];
            if (!wb[UV_EN_BIT])
                nxt_sys_opt[UV_FLAG_BIT] = 1'b0;
        end
        if (uv_set)
            nxt_sys_opt[UV_FLAG_BIT] = 1'b1;
        // core timer: writing 1 to a flag clears it, set wins
        if (core_wr)
        begin
            nxt_core_ctl[5:4] = wb[5:4];
            nxt_tick_rate     = pwdata_i[15:8];
            if (wb[TICK_FLAG_BIT])
                nxt_core_ctl[TICK_FLAG_BIT] = 1'b0;
            if (wb[WRAP_FLAG_BIT])
                nxt_core_ctl[WRAP_FLAG_BIT] = 1'b0;
        end
        if (timer_tick_i)
        begin
            nxt_core_cnt = core_cnt_ff + 8'h01;
            nxt_tick_cnt = tick_hit ? 8'h00 : tick_cnt_ff + 8'h01;
        end
        if (!core_ctl_ff[TICK_EN_BIT])
            nxt_tick_cnt = 8'h00;
        if (tick_hit)
            nxt_core_ctl[TICK_FLAG_BIT] = 1'b1;
        if (core_wrap & core_ctl_ff[WRAP_EN_BIT])
            nxt_core_ctl[WRAP_FLAG_BIT] = 1'b1;
        // keypad: write 1 to bit 1 clears flag
        if (kp_wr)
        begin
            nxt_kp_en = wb[0];
            if (wb[1])
                nxt_kp_flag = 1'b0;
        end
        if (kp_any)
            nxt_kp_flag = 1'b1;
        // cpu control and servicing
        if (cpu_wr & wb[MASK_BIT])
            nxt_mask = 1'b1;
        else if (cpu_wr)
            nxt_mask = 1'b0;
        if (ack)
        begin
            nxt_ext_latch = 1'b0;
            nxt_mask      = 1'b1;
        end
        if (irq_edge)
            nxt_ext_latch = 1'b1;
        if (insn_done & ~mask_ff & any_req)
        begin
            if (ext_req)
                nxt_vec = VEC_EXT;
            else if (core_req)
                nxt_vec = VEC_CORE;
            else if (tmr_req)
                nxt_vec = VEC_TMR;
            else
                nxt_vec = VEC_UV;
        end
        if (rsp)
            nxt_sp = SP_TOP;
        else if (push_int)
            nxt_sp = sp_ff - PUSH_INT_BYTES;
        else if (push_sub)
            nxt_sp = sp_ff - PUSH_SUB_BYTES;
        case (pwr_ff)
            RUN_S:
            begin
                if (cpu_wr & wb[STOP_BIT])
                    nxt_pwr = STOP_S;
                else if (cpu_wr & wb[WAIT_BIT])
                    nxt_pwr = WAIT_S;
            end
            WAIT_S:
            begin
                if (any_req)
                    nxt_pwr = RUN_S;
            end
            STOP_S:
            begin
                if (ext_req | uv_req | irq_edge | kp_any)
                    nxt_pwr = RUN_S;
            end
            default:
                nxt_pwr = RUN_S;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            sys_opt_ff   <= SYS_OPT_RST;
            core_ctl_ff  <= 8'h00;
            tick_rate_ff <= TICK_RATE_RST;
            core_cnt_ff  <= 8'h00;
            tick_cnt_ff  <= 8'h00;
            kp_en_ff     <= 1'b0;
            kp_flag_ff   <= 1'b0;
            ext_latch_ff <= 1'b0;
            mask_ff      <= 1'b1;
            sp_ff        <= SP_TOP;
            vec_ff       <= VEC_RESET;
            pwr_ff       <= RUN_S;
        end
        else
        begin
            sys_opt_ff   <= nxt_sys_opt;
            core_ctl_ff  <= nxt_core_ctl;
            tick_rate_ff <= nxt_tick_rate;
            core_cnt_ff  <= nxt_core_cnt;
            tick_cnt_ff  <= nxt_tick_cnt;
            kp_en_ff     <= nxt_kp_en;
            kp_flag_ff   <= nxt_kp_flag;
            ext_latch_ff <= nxt_ext_latch;
            mask_ff      <= nxt_mask;
            sp_ff        <= nxt_sp;
            vec_ff       <= nxt_vec;
            pwr_ff       <= nxt_pwr;
        end
    end

    // ------------------------------------------------------------
    // outputs and read mux
    // ------------------------------------------------------------
    assign cpu_irq_o     = any_req & ~mask_ff;
    assign vector_addr_o = vec_ff;
    assign stack_addr_o  = STACK_BASE | {10'h000, sp_ff};
    assign osc_run_o     = (pwr_ff != STOP_S);
    assign cpu_clk_run_o = (pwr_ff == RUN_S);
    assign pready_o      = 1'b1;

    logic [31:0] rd_word;
    logic        hit;
    always_comb
    begin
        rd_word = 32'h0000_0000;
        hit     = 1'b1;
        case (paddr_i)
            SYS_OPT_ADDR, SYS_OPT_OFF:
                rd_word = {24'h000000, sys_opt_ff[7:3], 3'h0};
            CORE_TMR_OFF:
                rd_word = {8'h00, core_cnt_ff, tick_rate_ff, core_ctl_ff[7:4], 4'h0};
            TMR_IRQ_OFF:
                rd_word = {22'h000000, timer_enables_i, timer_flags_i};
            KEYPAD_OFF:
                rd_word = {29'h00000000, kp_flag_ff, 1'b0, kp_en_ff};
            CPU_CTRL_OFF:
                rd_word = {26'h0000000, sp_ff};
            CPU_STAT_OFF:
                rd_word = {vec_ff, 8'h00, ext_latch_ff, pwr_ff, cpu_irq_o, any_req,
                           mask_ff, 1'b0};
            default:
                hit = 1'b0;
        endcase
    end

    logic [31:0] prdata_ff, nxt_prdata;
    always_comb
    begin
        nxt_prdata = prdata_ff;
        if (psel_i & ~penable_i & ~pwrite_i)
            nxt_prdata = rd_word;
    end
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
            prdata_ff <= 32'h0000_0000;
        else
            prdata_ff <= nxt_prdata;
    end
    assign prdata_o  = prdata_ff;
    assign pslverr_o = psel_i & penable_i & ~hit;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    a_mask_blocks_irq: assert property (insn_done && mask_ff |=> $stable(vec_ff))
        else $error("vector taken while masked");
    a_ext_pulse_held: assert property (irq_edge |=> ext_latch_ff)
        else $error("external pulse lost");
    a_wrap_flag_set: assert property (core_wrap && core_ctl_ff[WRAP_EN_BIT]
        |=> core_ctl_ff[WRAP_FLAG_BIT])
        else $error("wrap flag not set");
    a_uv_clear_en: assert property (sys_wr && !wb[UV_EN_BIT] && !uv_set
        |=> !sys_opt_ff[UV_FLAG_BIT])
        else $error("undervolt flag not cleared");
    a_uv_option: assert property (!undervolt_reset_opt_i && !sys_opt_ff[UV_FLAG_BIT]
        |=> !sys_opt_ff[UV_FLAG_BIT])
        else $error("undervolt flag without option");
    a_ext_priority: assert property (insn_done && !mask_ff && ext_req
        |=> vec_ff == VEC_EXT)
        else $error("external not first");
    a_stack_push: assert property (push_int && !rsp
        |=> sp_ff == $past(sp_ff) - PUSH_INT_BYTES)
        else $error("interrupt push not five");
    a_wait_wake: assert property (pwr_ff == WAIT_S && any_req |=> pwr_ff == RUN_S)
        else $error("wait not ended");
    a_stop_hold: assert property (pwr_ff == STOP_S && !ext_req && !uv_req && !irq_edge
        && !kp_any |=> pwr_ff == STOP_S)
        else $error("stop left without cause");
    a_rsp_top: assert property (rsp |=> sp_ff == SP_TOP)
        else $error("stack reset missed");

    c_ext_vector: cover property (insn_done && !mask_ff && ext_req);
    c_uv_vector:  cover property (vec_ff == VEC_UV);
    c_stop_wake:  cover property (pwr_ff == STOP_S ##1 pwr_ff == RUN_S);
    c_tick_flag:  cover property (tick_hit);

endmodule

// ### cpu_core_model.sv
// cpu_core_model: far-side cpu core that fetches the taken vector pair
// assumes vector_addr_i holds the high-byte address of the pair
module cpu_core_model
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_b_i,
    // from the block
    input  wire logic [15:0] vector_addr_i,
    // fetch addresses, high byte first
    output logic      [15:0] fetch_hi_o,
    output logic      [15:0] fetch_lo_o
);
    timeunit 1ns;
    timeprecision 1ns;

    // ------------------------------------------------------------
    // vector pair fetch
    // ------------------------------------------------------------
    assign fetch_hi_o = vector_addr_i;
    assign fetch_lo_o = vector_addr_i + 16'h0001;
endmodule

// ### irq_wake_ctrl_test.sv
// irq_wake_ctrl_test: apb tasks and directed sequences for irq_wake_ctrl
// assumes pready may stall, status read back over apb, vectors taken from the block outputs
module irq_wake_ctrl_test;
    timeunit 1ns;
    timeprecision 1ns;
    import irq_wake_pkg::*;

    logic        clk_i, rst_b, psel, penable, pwrite, irq_pin_b, uv_det, uv_opt, tick;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic        pready, pslverr, irq, osc_run, clk_run, e;
    logic [7:0]  kp_lines, kp_in;
    logic [4:0]  t_flags, t_en;
    logic [15:0] vec, stk, f_hi, f_lo;
    int          err_count, n_tests;

    irq_wake_ctrl dut (.clk_i(clk_i), .rst_b_i(rst_b), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .irq_pin_b_i(irq_pin_b),
        .keypad_lines_i(kp_lines), .keypad_is_input_i(kp_in), .undervolt_detect_i(uv_det),
        .undervolt_reset_opt_i(uv_opt), .timer_flags_i(t_flags), .timer_enables_i(t_en),
        .timer_tick_i(tick), .cpu_irq_o(irq), .vector_addr_o(vec), .stack_addr_o(stk),
        .osc_run_o(osc_run), .cpu_clk_run_o(clk_run));

    cpu_core_model cpu (.clk_i(clk_i), .rst_b_i(rst_b), .vector_addr_i(vec),
        .fetch_hi_o(f_hi), .fetch_lo_o(f_lo));

    // ------------------------------------------------------------
    // clock, tasks
    // ------------------------------------------------------------
    initial
    begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_i);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        do
        begin
            @(posedge clk_i);
        end
        while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask

    task automatic rd(input logic [11:0] a);
        xfer(1'b0, a, 32'h0000_0000);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    task automatic ticks(input int n);
        repeat (n)
        begin
            @(posedge clk_i);
            tick <= 1'b1;
            @(posedge clk_i);
            tick <= 1'b0;
        end
        #1;
    endtask

    task automatic test_done;
        $display("checks %0d errors %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge clk_i);
        err_count++;
        test_done();
    end

    // ------------------------------------------------------------
    // sequences
    // ------------------------------------------------------------
    initial
    begin
        {rst_b, psel, penable, pwrite, tick, uv_det, uv_opt} = 7'h00;
        {paddr, pwdata, t_flags, t_en, kp_lines} = 62'h0;
        irq_pin_b = 1'b1;
        kp_in = 8'hFF;
        err_count = 0;
        n_tests = 0;
        repeat (20) @(posedge clk_i);
        rst_b <= 1'b1;
        rd(SYS_OPT_OFF);
        chk("sys_opt reset", q, {24'h0, SYS_OPT_RST});
        chk("vector reset", {16'h0, f_hi}, {16'h0, VEC_RESET});
        rd(CPU_STAT_OFF);
        chk("mask reset", {31'h0, q[1]}, 32'h1);
        chk("stack reset", {16'h0, stk}, 32'h00FF);
        rd(12'hFF0);
        chk("unmapped err", {31'h0, e}, 32'h1);
        wr(SYS_OPT_OFF, 32'hFF);
        rd(SYS_OPT_OFF);
        chk("sys_opt rw", q, 32'h78);
        wr(SYS_OPT_OFF, 32'h00);
        // pin pulse while masked is held
        @(posedge clk_i);
        irq_pin_b <= 1'b0;
        cyc(3);
        irq_pin_b <= 1'b1;
        cyc(4);
        chk("irq masked", {31'h0, irq}, 32'h0);
        wr(CPU_CTRL_OFF, 32'h00);
        chk("irq unmasked", {31'h0, irq}, 32'h1);
        chk("vector pending", {16'h0, vec}, {16'h0, VEC_RESET});
        wr(CPU_CTRL_OFF, 32'h08);
        chk("vector ext", {16'h0, vec}, {16'h0, VEC_EXT});
        wr(CPU_CTRL_OFF, 32'h10);
        chk("irq after ack", {31'h0, irq}, 32'h0);
        // edge-only versus edge-and-level
        @(posedge clk_i);
        irq_pin_b <= 1'b0;
        cyc(5);
        wr(CPU_CTRL_OFF, 32'h10);
        wr(CPU_CTRL_OFF, 32'h00);
        chk("edge only", {31'h0, irq}, 32'h0);
        wr(SYS_OPT_OFF, 32'h08);
        chk("level sense", {31'h0, irq}, 32'h1);
        @(posedge clk_i);
        irq_pin_b <= 1'b1;
        cyc(4);
        wr(SYS_OPT_OFF, 32'h00);
        wr(CPU_CTRL_OFF, 32'h10);
        // keypad outranks 16-bit timer; output lines ignored
        @(posedge clk_i);
        t_flags  <= 5'h04;
        t_en     <= 5'h04;
        kp_lines <= 8'h10;
        kp_in    <= 8'hEF;
        wr(KEYPAD_OFF, 32'h01);
        cyc(4);
        rd(KEYPAD_OFF);
        chk("keypad output line", {31'h0, q[2]}, 32'h0);
        @(posedge clk_i);
        kp_in <= 8'hFF;
        cyc(4);
        wr(CPU_CTRL_OFF, 32'h00);
        wr(CPU_CTRL_OFF, 32'h08);
        chk("vector keypad", {16'h0, vec}, {16'h0, VEC_EXT});
        kp_lines <= 8'h00;
        cyc(4);
        wr(KEYPAD_OFF, 32'h03);
        rd(KEYPAD_OFF);
        chk("keypad flag", {31'h0, q[2]}, 32'h0);
        wr(CPU_CTRL_OFF, 32'h08);
        chk("vector timer", {16'h0, vec}, {16'h0, VEC_TMR});
        // core timer tick, then wrap, both outrank 16-bit timer
        wr(CORE_TMR_OFF, 32'h0000_0420);
        ticks(12);
        rd(CORE_TMR_OFF);
        chk("tick flag", {31'h0, q[7]}, 32'h1);
        wr(CPU_CTRL_OFF, 32'h08);
        chk("vector tick", {16'h0, vec}, {16'h0, VEC_CORE});
        wr(CORE_TMR_OFF, 32'h0000_0090);
        ticks(257);
        rd(CORE_TMR_OFF);
        chk("wrap flag", {30'h0, q[7:6]}, 32'h1);
        wr(CPU_CTRL_OFF, 32'h08);
        chk("vector wrap", {16'h0, vec}, {16'h0, VEC_CORE});
        wr(CORE_TMR_OFF, 32'h0000_0040);
        // undervolt: power before enable, option gates, enable clears
        @(posedge clk_i);
        t_flags <= 5'h00;
        uv_det  <= 1'b1;
        wr(SYS_OPT_OFF, 32'h20);
        wr(SYS_OPT_OFF, 32'h60);
        cyc(4);
        rd(SYS_OPT_OFF);
        chk("uv no option", q, 32'h60);
        uv_opt <= 1'b1;
        cyc(4);
        rd(SYS_OPT_OFF);
        chk("uv flag set", q, 32'hE0);
        chk("uv irq", {31'h0, irq}, 32'h1);
        wr(CPU_CTRL_OFF, 32'h08);
        chk("vector uv", {f_hi, f_lo}, {VEC_UV, 16'h3FF5});
        uv_det <= 1'b0;
        cyc(3);
        wr(SYS_OPT_OFF, 32'hA0);
        rd(SYS_OPT_OFF);
        chk("uv flag clear", q, 32'h20);
        // stack pointer
        wr(CPU_CTRL_OFF, 32'h41);
        chk("push int", {16'h0, stk}, 32'h00FA);
        wr(CPU_CTRL_OFF, 32'h81);
        chk("push call", {16'h0, stk}, 32'h00F8);
        repeat (12) wr(CPU_CTRL_OFF, 32'h41);
        chk("stack wrap", {16'h0, stk}, 32'h00FC);
        wr(CPU_CTRL_OFF, 32'h21);
        chk("stack rsp", {16'h0, stk}, 32'h00FF);
        // wait wakes on timer, stop does not
        wr(CPU_CTRL_OFF, 32'h05);
        chk("wait clocks", {30'h0, osc_run, clk_run}, 32'h2);
        t_flags <= 5'h04;
        cyc(3);
        chk("wait wake", {31'h0, clk_run}, 32'h1);
        wr(CPU_CTRL_OFF, 32'h03);
        cyc(5);
        chk("stop held", {31'h0, osc_run}, 32'h0);
        irq_pin_b <= 1'b0;
        cyc(5);
        chk("stop wake", {31'h0, osc_run}, 32'h1);
        irq_pin_b <= 1'b1;
        // second reset mid-run
        wr(CPU_CTRL_OFF, 32'h41);
        rst_b <= 1'b0;
        cyc(2);
        rst_b <= 1'b1;
        cyc(1);
        chk("rst2 vector", {16'h0, vec}, {16'h0, VEC_RESET});
        chk("rst2 stack", {16'h0, stk}, 32'h00FF);
        test_done();
    end
endmodule
